// ---- design/sfp_pkg.sv ----
// Package for the serial flash transfer pause block
package sfp_pkg;

    // Pin sampling and command shift widths
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned SHIFT_W     = 8;
    localparam logic [2:0]  BIT_CNT_RST = 3'h0;
    localparam logic [7:0]  SHIFT_RST   = 8'h00;
    localparam logic        WEL_RST     = 1'b0;

    // Pause state machine
    typedef enum logic [1:0] {
        SFP_IDLE,
        SFP_ACTIVE,
        SFP_PAUSED
    } sfp_state_e;

    // Synchronised pin levels from the host
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic pause_n;
        logic wp_n;
    } sfp_pins_s;

    // Quad data line drive toward the pause pin
    typedef struct packed {
        logic out;
        logic oe;
    } sfp_drive_s;

endpackage

// ---- design/sfp_core.sv ----
// Pause control for the serial interface of a serial flash device
`timescale 1ns/1ps

// Overview of operation
// - A low pause pin freezes the transfer while the host clock keeps running.
// - Internal program or erase busy time keeps counting while paused.
// - With the quad enable bit at 1 the pause pin is a quad data line, not a control.
// - Pause is entered only with chip select low and at a clock-low phase.
// - A pause asserted while the clock is high waits for the next clock-low phase.
// - The pause lasts while both the pause pin and chip select stay low.
// - While paused the serial output is not driven.
// - While paused the serial input and clock edges are ignored.
// - Write protect changes are still followed during the pause.
// - A release while the clock is high keeps the pause until the next clock-low phase.
// - Chip select high while paused aborts the operation and clears the write enable latch.
module sfp_core (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             cs_n,
    input  wire logic             sck,
    input  wire logic             si,
    input  wire logic             pause_n_in,
    input  wire logic             wp_n,
    input  wire logic             quad_io_enable_bit,
    input  wire logic             quad_mode,
    input  wire logic             quad_data_out,
    input  wire logic             quad_data_oe,
    input  wire logic             so_data,
    input  wire logic             so_drive,
    input  wire logic             wel_set,
    input  wire logic             op_busy,
    output logic                  pause_n_out,
    output logic                  pause_n_oe,
    output logic                  so_out,
    output logic                  so_oe,
    output logic                  paused,
    output logic                  sck_rise,
    output logic                  sck_fall,
    output logic [7:0]            shift_byte,
    output logic [2:0]            bit_count,
    output logic                  byte_done,
    output logic                  op_abort,
    output logic                  write_enable_latch,
    output logic                  wp_active,
    output logic                  busy_out
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    // Edge of a synchronised level against its delayed copy
    function automatic logic level_edge(
        input logic cur,
        input logic prev,
        input logic rising
    );
        logic hit;
        if (rising) begin
            hit = cur & ~prev;
        end else begin
            hit = ~cur & prev;
        end
        return hit;
    endfunction

    // A pause pin change of pause state only in a clock-low phase
    // Entry and release both wait for it; chip select high leaves the pause at once
    function automatic logic phase_ok(
        input logic sck_level,
        input logic want
    );
        return want & ~sck_level;
    endfunction

    // True when a state register holds the given state
    function automatic logic state_is(
        input sfp_pkg::sfp_state_e cur,
        input sfp_pkg::sfp_state_e want
    );
        return cur == want;
    endfunction

    // Pin levels that mean no host activity
    function automatic sfp_pkg::sfp_pins_s pins_idle();
        sfp_pkg::sfp_pins_s p;
        p.cs_n    = 1'b1;
        p.sck     = 1'b0;
        p.si      = 1'b0;
        p.pause_n = 1'b1;
        p.wp_n    = 1'b1;
        return p;
    endfunction

    // Command bits arrive msb first
    function automatic logic [7:0] shift_in(
        input logic [7:0] cur,
        input logic       bit_in
    );
        return {cur[6:0], bit_in};
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    sfp_pkg::sfp_pins_s meta_reg;
    sfp_pkg::sfp_pins_s meta_next;
    sfp_pkg::sfp_pins_s sync_reg;
    sfp_pkg::sfp_pins_s sync_next;
    logic               sck_d_reg;
    logic               sck_d_next;

    always_comb begin
        meta_next  = '{cs_n: cs_n, sck: sck, si: si, pause_n: pause_n_in, wp_n: wp_n};
        sync_next  = meta_reg;
        sck_d_next = sync_reg.sck;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_reg  <= pins_idle();
            sync_reg  <= pins_idle();
            sck_d_reg <= 1'b0;
        end else begin
            meta_reg  <= meta_next;
            sync_reg  <= sync_next;
            sck_d_reg <= sck_d_next;
        end
    end

    logic cs_act;
    logic pause_req;
    logic raw_rise;
    logic raw_fall;

    assign cs_act    = ~sync_reg.cs_n;
    assign pause_req = ~sync_reg.pause_n & ~quad_io_enable_bit;
    assign raw_rise  = level_edge(sync_reg.sck, sck_d_reg, 1'b1);
    assign raw_fall  = level_edge(sync_reg.sck, sck_d_reg, 1'b0);

    // ------------------------------------------------------------
    // Pause state machine
    // ------------------------------------------------------------
    sfp_pkg::sfp_state_e state_reg;
    sfp_pkg::sfp_state_e state_next;
    logic                abort_next;

    always_comb begin
        state_next = state_reg;
        abort_next = 1'b0;
        case (state_reg)
            sfp_pkg::SFP_IDLE: begin
                if (cs_act) begin
                    state_next = sfp_pkg::SFP_ACTIVE;
                end
            end
            sfp_pkg::SFP_ACTIVE: begin
                if (!cs_act) begin
                    state_next = sfp_pkg::SFP_IDLE;
                    abort_next = pause_req;
                end else if (phase_ok(sync_reg.sck, pause_req)) begin
                    state_next = sfp_pkg::SFP_PAUSED;
                end
            end
            sfp_pkg::SFP_PAUSED: begin
                if (!cs_act) begin
                    state_next = sfp_pkg::SFP_IDLE;
                    abort_next = 1'b1;
                end else if (phase_ok(sync_reg.sck, !pause_req)) begin
                    state_next = sfp_pkg::SFP_ACTIVE;
                end
            end
            default: begin
                state_next = sfp_pkg::SFP_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= sfp_pkg::SFP_IDLE;
            op_abort  <= 1'b0;
        end else begin
            state_reg <= state_next;
            op_abort  <= abort_next;
        end
    end

    logic is_paused;
    logic shifting;

    assign is_paused = state_is(state_reg, sfp_pkg::SFP_PAUSED);
    assign shifting  = state_is(state_reg, sfp_pkg::SFP_ACTIVE) && cs_act;
    assign paused    = is_paused;

    // ------------------------------------------------------------
    // Command shift, frozen while paused
    // ------------------------------------------------------------
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic       done_next;
    logic       rise_next;
    logic       fall_next;

    always_comb begin
        shift_next = shift_reg;
        cnt_next   = cnt_reg;
        done_next  = 1'b0;
        rise_next  = shifting & raw_rise;
        fall_next  = shifting & raw_fall;
        if (!cs_act) begin
            shift_next = sfp_pkg::SHIFT_RST;
            cnt_next   = sfp_pkg::BIT_CNT_RST;
        end else if (rise_next) begin
            shift_next = shift_in(shift_reg, sync_reg.si);
            cnt_next   = 3'(cnt_reg + 3'h1);
            done_next  = (cnt_reg == 3'h7);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            shift_reg <= sfp_pkg::SHIFT_RST;
            cnt_reg   <= sfp_pkg::BIT_CNT_RST;
            byte_done <= 1'b0;
            sck_rise  <= 1'b0;
            sck_fall  <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            cnt_reg   <= cnt_next;
            byte_done <= done_next;
            sck_rise  <= rise_next;
            sck_fall  <= fall_next;
        end
    end

    assign shift_byte = shift_reg;
    assign bit_count  = cnt_reg;

    // ------------------------------------------------------------
    // Write enable latch, write protect and busy
    // ------------------------------------------------------------
    logic wel_next;
    logic wp_next;
    logic busy_next;

    always_comb begin
        wel_next  = write_enable_latch;
        if (abort_next) begin
            wel_next = 1'b0;
        end else if (wel_set) begin
            wel_next = 1'b1;
        end
        wp_next   = ~sync_reg.wp_n;
        busy_next = op_busy;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            write_enable_latch <= sfp_pkg::WEL_RST;
            wp_active          <= 1'b0;
            busy_out           <= 1'b0;
        end else begin
            write_enable_latch <= wel_next;
            wp_active          <= wp_next;
            busy_out           <= busy_next;
        end
    end

    // ------------------------------------------------------------
    // Output drivers
    // ------------------------------------------------------------
    logic               so_out_next;
    logic               so_oe_next;
    sfp_pkg::sfp_drive_s qd_reg;
    sfp_pkg::sfp_drive_s qd_next;

    always_comb begin
        so_out_next = so_data;
        so_oe_next  = so_drive & cs_act & ~is_paused
                    & ~state_is(state_next, sfp_pkg::SFP_PAUSED);
        qd_next.out = quad_data_out;
        qd_next.oe  = quad_io_enable_bit & quad_mode & quad_data_oe & cs_act;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            so_out <= 1'b0;
            so_oe  <= 1'b0;
            qd_reg <= '{out: 1'b0, oe: 1'b0};
        end else begin
            so_out <= so_out_next;
            so_oe  <= so_oe_next;
            qd_reg <= qd_next;
        end
    end

    assign pause_n_out = qd_reg.out;
    assign pause_n_oe  = qd_reg.oe;

endmodule

// ---- verification/sfp_core_checker.sv ----
// Port assertions for the pause control block
`timescale 1ns/1ps
module sfp_core_checker (
    input logic sys_clk,
    input logic sys_rst,
    input logic cs_n,
    input logic sck,
    input logic pause_n_in,
    input logic quad_io_enable_bit,
    input logic so_oe,
    input logic paused,
    input logic sck_rise,
    input logic op_abort,
    input logic write_enable_latch
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    property p_hiz; paused |-> !so_oe; endproperty
    a_hiz: assert property (p_hiz) else $error("so driven");
    property p_frz; paused && $past(paused) |-> !sck_rise; endproperty
    a_frz: assert property (p_frz) else $error("sck taken");
    property p_qe; $past(quad_io_enable_bit) |-> !$rose(paused); endproperty
    a_qe: assert property (p_qe) else $error("quad pause");
    property p_ent; $rose(paused) |-> !pause_n_in && !cs_n; endproperty
    a_ent: assert property (p_ent) else $error("bad entry");
    property p_hi; sck [*5] |-> !$rose(paused); endproperty
    a_hi: assert property (p_hi) else $error("entry in high");
    property p_cs; cs_n [*6] |-> !paused; endproperty
    a_cs: assert property (p_cs) else $error("no select");
    property p_ext; (pause_n_in && !sck) [*5] |-> !paused; endproperty
    a_ext: assert property (p_ext) else $error("exit late");
    property p_abt; op_abort |-> !write_enable_latch; endproperty
    a_abt: assert property (p_abt) else $error("latch kept");
    c_ent: cover property ($rose(paused));
    c_ext: cover property ($fell(paused));
    c_abt: cover property (op_abort);
endmodule
bind sfp_core sfp_core_checker i_sfp_core_checker (.*);

// ---- verification/sfp_host_model.sv ----
// Host controller model driving the serial flash pins
`timescale 1ns/1ps
module sfp_host_model (
    output logic cs_n    = 1'b1,
    output logic sck     = 1'b0,
    output logic si      = 1'b0,
    output logic pause_n = 1'b1,
    output logic wp_n    = 1'b1
);
    // Clock moves only inside frames and rests low
    task step(input logic c, input logic p, input logic s);
        cs_n = c;
        pause_n = p;
        sck = s;
        #62.5;
    endtask
    task bits(input logic [7:0] d, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            si = d[i];
            step(cs_n, pause_n, 1'b0);
            step(cs_n, pause_n, 1'b1);
        end
        step(cs_n, pause_n, 1'b0);
    endtask
endmodule

// ---- verification/sfp_core_tb_top.sv ----
// Self-checking bench for the pause control block
`timescale 1ns/1ps
module sfp_core_tb_top;
    logic       sys_clk = 1'b0, sys_rst = 1'b1, wel_set = 1'b0, op_busy = 1'b0;
    logic       quad_io_enable_bit = 1'b0;
    logic       quad_mode = 1'b0, quad_data_out = 1'b1, quad_data_oe = 1'b0;
    logic       so_data = 1'b1, so_drive = 1'b1;
    logic       so_out, sck_rise, sck_fall, byte_done;
    int         n_rise = 0, n_fall = 0, n_done = 0;
    logic       cs_n, sck, si, pause_n, wp_n, pause_n_in, pause_n_out, pause_n_oe, so_oe;
    logic       paused, op_abort, write_enable_latch, wp_active, busy_out;
    logic [7:0] shift_byte;
    logic [2:0] bit_count;
    int         n_mismatch = 0, checked = 0;
    always #5 sys_clk = ~sys_clk;
    // Device drive wins on the shared pause pin
    assign pause_n_in = pause_n_oe ? pause_n_out : pause_n;
    sfp_host_model i_host (.*);
    sfp_core i_sfp_core (.*);
    // Pulse counters for the qualified clock edges and byte ends
    always @(posedge sys_clk) begin
        if (sck_rise === 1'b1) n_rise <= n_rise + 1;
        if (sck_fall === 1'b1) n_fall <= n_fall + 1;
        if (byte_done === 1'b1) n_done <= n_done + 1;
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) n_mismatch++;
        if (seen !== exp) $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    endtask
    task close_out;
        $display("Checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task sc_pause;
        @(posedge sys_clk) op_busy <= 1'b1;
        #1;
        i_host.step(1'b0, 1'b1, 1'b0);
        i_host.bits(8'hc3, 4);
        chk(8'(so_oe), 8'h01);
        chk(8'(so_out), 8'h01);
        i_host.step(1'b0, 1'b0, 1'b0);
        chk(8'(paused), 8'h01);
        chk(8'(so_oe), 8'h00);
        chk(8'(busy_out), 8'h01);
        i_host.bits(8'hff, 3);
        chk(8'(bit_count), 8'h04);
        i_host.step(1'b0, 1'b0, 1'b1);
        i_host.step(1'b0, 1'b1, 1'b1);
        chk(8'(paused), 8'h01);
        i_host.step(1'b0, 1'b1, 1'b0);
        chk(8'(paused), 8'h00);
        i_host.bits(8'h30, 4);
        chk(shift_byte, 8'hc3);
        chk(8'(n_rise), 8'h08);
        chk(8'(n_fall), 8'h08);
        chk(8'(n_done), 8'h01);
        i_host.step(1'b1, 1'b1, 1'b0);
    endtask
    task sc_abort;
        @(posedge sys_clk) wel_set <= 1'b1;
        so_data <= 1'b0;
        @(posedge sys_clk) wel_set <= 1'b0;
        #1;
        i_host.step(1'b0, 1'b1, 1'b0);
        chk(8'(write_enable_latch), 8'h01);
        chk(8'(so_out), 8'h00);
        i_host.step(1'b0, 1'b1, 1'b1);
        i_host.step(1'b0, 1'b0, 1'b1);
        chk(8'(paused), 8'h00);
        i_host.step(1'b0, 1'b0, 1'b0);
        chk(8'(paused), 8'h01);
        i_host.wp_n = 1'b0;
        #50;
        chk(8'(wp_active), 8'h01);
        i_host.cs_n = 1'b1;
        for (int i = 0; i < 20 && op_abort !== 1'b1; i++) #10;
        chk(8'(op_abort), 8'h01);
        chk(8'(write_enable_latch), 8'h00);
    endtask
    task sc_quad;
        @(posedge sys_clk);
        quad_io_enable_bit <= 1'b1;
        quad_mode          <= 1'b1;
        quad_data_oe       <= 1'b1;
        quad_data_out      <= 1'b0;
        #1;
        i_host.step(1'b0, 1'b0, 1'b0);
        chk(8'(paused), 8'h00);
        chk(8'(pause_n_oe), 8'h01);
        chk(8'(pause_n_out), 8'h00);
        i_host.step(1'b1, 1'b1, 1'b0);
        chk(8'(pause_n_oe), 8'h00);
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        sc_pause;
        sc_abort;
        sc_quad;
        close_out;
    end
endmodule
